// File: core/safety_interlock.sv
// Functional notes
// - Safety outputs both low is the safe state; low when not enabled.
// - Green power indicator when ready; output table only while ready.
// - Actuator present: each safety output follows its own safety input.
// - No actuator: both safety outputs and signal output low.
// - One input falls, other high: input indicator flashes (unequal).
// - That input rises again, other still high: lock, indicator flashes.
// - Normal switching resumes only after both inputs were low together or the supply dropped.
// - With nothing learned, the first compatible actuator is learned.
// - At most eight teach-ins; no learning once the counter is empty.
// - New actuator taught only as sole transponder; gate flashes slowly.
// - After 20 s presence the gate indicator flashes fast.
// - Power interruption within 120 s of fast flashing confirms teach.
// - Next power-up stores the new actuator and decrements the count.
// - A replaced actuator is rejected permanently, never learned again.
// - Input indicator keeps flashing under lock until both inputs open or the supply drops.
`include "interlock_params.svh"
`default_nettype none
module safety_interlock
   import interlock_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `MS_CYCLES,
   parameter int unsigned READY_MS = `READY_DELAY_S * `MS_PER_S,
   parameter int unsigned DETECT_MS = `TEACH_DETECT_S * `MS_PER_S,
   parameter int unsigned CONFIRM_MS = `TEACH_CONFIRM_S * `MS_PER_S
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SUPPLY_OK,
   input wire logic TAG_VALID,
   input wire logic TAG_SOLE,
   input wire logic [`ID_W-1:0] TAG_ID,
   input wire logic SAFETY_IN_CH1,
   input wire logic SAFETY_IN_CH2,
   output var logic SAFETY_OUT_CH1,
   output var logic SAFETY_OUT_CH2,
   output var logic PRESENCE_SIGNAL_OUT,
   output var logic LED_POWER_GREEN,
   output var logic LED_GATE,
   output var logic LED_INPUT,
   output var logic [`CNT_W-1:0] LEARN_REMAINING
);

   teach_if tif ();

   logic [`MSDIV_W-1:0] div_cnt, next_div_cnt;
   logic tick_ms, next_tick_ms;
   logic [`FLASH_W-1:0] flash_cnt, next_flash_cnt;
   logic [`TIMER_W-1:0] ready_cnt, next_ready_cnt;
   logic ready, next_ready;
   plaus_state_t st, next_st;
   logic fell_ch, next_fell_ch;
   logic in_q1, in_q2;
   logic fallen_in, other_in;
   logic enable;
   logic next_out1, next_out2, next_presence;
   logic next_led_green, next_led_gate, next_led_input;

   // all checks below run on the one clock, off during reset
   default clocking dck @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   // millisecond tick divider
   always_comb begin
      if (div_cnt == `MSDIV_W'(MS_CYCLES - 1)) begin
         next_div_cnt = '0;
         next_tick_ms = 1'b1;
      end else begin
         next_div_cnt = div_cnt + 1'b1;
         next_tick_ms = 1'b0;
      end
      next_flash_cnt = tick_ms ? flash_cnt + 1'b1 : flash_cnt;
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_cnt <= '0;
         tick_ms <= 1'b0;
         flash_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
         tick_ms <= next_tick_ms;
         flash_cnt <= next_flash_cnt;
      end
   end

   // switch-on delay after supply returns
   always_comb begin
      next_ready_cnt = ready_cnt;
      next_ready = ready;
      if (!SUPPLY_OK) begin
         next_ready_cnt = '0;
         next_ready = 1'b0;
      end else if (!ready && tick_ms) begin
         if (ready_cnt == `TIMER_W'(READY_MS - 1)) begin
            next_ready = 1'b1;
         end else begin
            next_ready_cnt = ready_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ready_cnt <= '0;
         ready <= 1'b0;
      end else begin
         ready_cnt <= next_ready_cnt;
         ready <= next_ready;
      end
   end

   // input plausibility monitor
   always_comb begin
      next_st = st;
      next_fell_ch = fell_ch;
      fallen_in = fell_ch ? SAFETY_IN_CH2 : SAFETY_IN_CH1;
      other_in = fell_ch ? SAFETY_IN_CH1 : SAFETY_IN_CH2;
      if (!SUPPLY_OK) begin
         next_st = ST_NORM;
      end else begin
         unique case (st)
            ST_NORM: begin
               if (in_q1 && !SAFETY_IN_CH1 && SAFETY_IN_CH2) begin
                  next_st = ST_UNEQ;
                  next_fell_ch = 1'b0;
               end else if (in_q2 && !SAFETY_IN_CH2 && SAFETY_IN_CH1) begin
                  next_st = ST_UNEQ;
                  next_fell_ch = 1'b1;
               end
            end
            ST_UNEQ: begin
               if (!SAFETY_IN_CH1 && !SAFETY_IN_CH2) begin
                  next_st = ST_NORM;
               end else if (fallen_in && other_in) begin
                  next_st = ST_LOCK;
               end else if (fallen_in) begin
                  next_fell_ch = ~fell_ch; // channels swapped over
               end
            end
            ST_LOCK: begin
               if (!SAFETY_IN_CH1 && !SAFETY_IN_CH2) begin
                  next_st = ST_NORM;
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st <= ST_NORM;
         fell_ch <= 1'b0;
         in_q1 <= 1'b0;
         in_q2 <= 1'b0;
      end else begin
         st <= next_st;
         fell_ch <= next_fell_ch;
         in_q1 <= SAFETY_IN_CH1;
         in_q2 <= SAFETY_IN_CH2;
      end
   end

   // teach-in sequencer and retained store
   assign tif.tick_ms = tick_ms;
   assign tif.supply_ok = SUPPLY_OK;
   assign tif.ready = ready;
   assign tif.tag_valid = TAG_VALID;
   assign tif.tag_sole = TAG_SOLE;
   assign tif.tag_id = TAG_ID;

   teach_unit #(
      .DETECT_MS(DETECT_MS),
      .CONFIRM_MS(CONFIRM_MS)
   ) u_teach (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .tif(tif)
   );

   // output and indicator values
   always_comb begin
      enable = ready && tif.learned_match && st != ST_LOCK;
      next_out1 = enable && SAFETY_IN_CH1;
      next_out2 = enable && SAFETY_IN_CH2;
      next_presence = ready && tif.learned_match;
      next_led_green = ready;
      if (!ready) begin
         next_led_gate = 1'b0;
      end else if (tif.teach_fast) begin
         next_led_gate = flash_cnt[`FAST_BIT];
      end else if (tif.teach_slow) begin
         next_led_gate = flash_cnt[`SLOW_BIT];
      end else begin
         next_led_gate = tif.learned_match;
      end
      if (st != ST_NORM) begin
         next_led_input = flash_cnt[`INPUT_BIT];
      end else begin
         next_led_input = SAFETY_IN_CH1 && SAFETY_IN_CH2;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         SAFETY_OUT_CH1 <= 1'b0;
         SAFETY_OUT_CH2 <= 1'b0;
         PRESENCE_SIGNAL_OUT <= 1'b0;
         LED_POWER_GREEN <= 1'b0;
         LED_GATE <= 1'b0;
         LED_INPUT <= 1'b0;
         LEARN_REMAINING <= `LEARN_MAX;
      end else begin
         SAFETY_OUT_CH1 <= next_out1;
         SAFETY_OUT_CH2 <= next_out2;
         PRESENCE_SIGNAL_OUT <= next_presence;
         LED_POWER_GREEN <= next_led_green;
         LED_GATE <= next_led_gate;
         LED_INPUT <= next_led_input;
         LEARN_REMAINING <= tif.remaining;
      end
   end

   AST_SAFE_LOW: assert property (
      !ready |=> (!SAFETY_OUT_CH1 && !SAFETY_OUT_CH2))
      else $error("safety output high while not ready");
   AST_READY_LED: assert property (
      ready |=> LED_POWER_GREEN)
      else $error("green indicator off while ready");
   AST_FOLLOW: assert property (
      (ready && tif.learned_match && st != ST_LOCK) |=>
      (SAFETY_OUT_CH1 == $past(SAFETY_IN_CH1) &&
       SAFETY_OUT_CH2 == $past(SAFETY_IN_CH2)))
      else $error("safety output does not follow its input");
   AST_ABSENT: assert property (
      !tif.learned_match |=>
      (!SAFETY_OUT_CH1 && !SAFETY_OUT_CH2 && !PRESENCE_SIGNAL_OUT))
      else $error("output high without actuator");
   AST_PRESENCE: assert property (
      (ready && tif.learned_match) |=> PRESENCE_SIGNAL_OUT)
      else $error("signal output low with actuator present");
   AST_UNEQUAL: assert property (
      (st == ST_NORM && SUPPLY_OK && $fell(SAFETY_IN_CH1) && SAFETY_IN_CH2)
      |=> (st == ST_UNEQ ##1 LED_INPUT == $past(flash_cnt[`INPUT_BIT])))
      else $error("unequal inputs not flagged");
   AST_LOCK: assert property (
      (st == ST_UNEQ && SUPPLY_OK && SAFETY_IN_CH1 && SAFETY_IN_CH2)
      |=> (st == ST_LOCK ##1 (!SAFETY_OUT_CH1 && !SAFETY_OUT_CH2)))
      else $error("plausibility lock not raised");
   AST_LOCK_HOLD: assert property (
      (st == ST_LOCK && SUPPLY_OK && (SAFETY_IN_CH1 || SAFETY_IN_CH2))
      |=> st == ST_LOCK)
      else $error("lock released without both inputs low");
   AST_LOCK_FLASH: assert property (
      st == ST_LOCK |=> LED_INPUT == $past(flash_cnt[`INPUT_BIT]))
      else $error("input indicator not flashing under lock");

endmodule : safety_interlock
`default_nettype wire

// File: core/interlock_params.svh
`ifndef INTERLOCK_PARAMS_SVH
`define INTERLOCK_PARAMS_SVH

// clock rate and millisecond divider
`define CLK_HZ 50000000
`define MS_PER_S 1000
`define MS_CYCLES (`CLK_HZ / `MS_PER_S)
`define MSDIV_W 16

// times in seconds, converted to millisecond ticks by the modules
`define READY_DELAY_S 1
`define TEACH_DETECT_S 20
`define TEACH_CONFIRM_S 120
`define TIMER_W 17

// transponder identity and learning counter
`define ID_W 8
`define CNT_W 4
`define LEARN_MAX 4'h8
`define REJECT_DEPTH 8
`define REJECT_IDX_W 3

// indicator flash rates: bits of a free-running millisecond counter
`define FLASH_W 10
`define SLOW_BIT 9
`define INPUT_BIT 8
`define FAST_BIT 7

`endif

// File: core/interlock_pkg.sv
`include "interlock_params.svh"
`default_nettype none
package interlock_pkg;

   typedef logic [`ID_W-1:0] tag_id_t;

   // input plausibility states
   typedef enum logic [1:0] {
      ST_NORM = 2'b00,
      ST_UNEQ = 2'b01,
      ST_LOCK = 2'b11
   } plaus_state_t;

   // teach-in states
   typedef enum logic [1:0] {
      T_IDLE   = 2'b00,
      T_DETECT = 2'b01,
      T_WINDOW = 2'b11,
      T_ARMED  = 2'b10
   } teach_state_t;

endpackage : interlock_pkg
`default_nettype wire

// File: core/teach_if.sv
`include "interlock_params.svh"
`default_nettype none
interface teach_if import interlock_pkg::*; ();
   logic tick_ms;
   logic supply_ok;
   logic ready;
   logic tag_valid;
   logic tag_sole;
   tag_id_t tag_id;
   logic learned_match;
   logic teach_slow;
   logic teach_fast;
   logic [`CNT_W-1:0] remaining;

   modport ctrl (
      output tick_ms, supply_ok, ready, tag_valid, tag_sole, tag_id,
      input learned_match, teach_slow, teach_fast, remaining
   );
   modport unit (
      input tick_ms, supply_ok, ready, tag_valid, tag_sole, tag_id,
      output learned_match, teach_slow, teach_fast, remaining
   );
endinterface : teach_if
`default_nettype wire

// File: core/teach_unit.sv
`include "interlock_params.svh"
`default_nettype none
module teach_unit
   import interlock_pkg::*;
#(
   parameter int unsigned DETECT_MS = `TEACH_DETECT_S * `MS_PER_S,
   parameter int unsigned CONFIRM_MS = `TEACH_CONFIRM_S * `MS_PER_S
) (
   input wire logic clk,
   input wire logic rst_n,
   teach_if.unit tif
);

   // retained store: learned actuator, counter, replaced actuators
   logic learned_valid;
   tag_id_t learned_id;
   logic [`CNT_W-1:0] remaining;
   tag_id_t reject_id [`REJECT_DEPTH];
   logic [`REJECT_DEPTH-1:0] reject_valid;
   tag_id_t cand_id;
   teach_state_t st;
   logic [`TIMER_W-1:0] timer;

   logic next_learned_valid;
   tag_id_t next_learned_id;
   logic [`CNT_W-1:0] next_remaining;
   tag_id_t next_reject_id [`REJECT_DEPTH];
   logic [`REJECT_DEPTH-1:0] next_reject_valid;
   tag_id_t next_cand_id;
   teach_state_t next_st;
   logic [`TIMER_W-1:0] next_timer;
   logic [`REJECT_IDX_W-1:0] slot;
   logic cand_lost;

   // all checks below run on the one clock, off during reset
   default clocking dck @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // id found among replaced actuators
   function automatic logic is_rejected(input tag_id_t id,
         input tag_id_t ids [`REJECT_DEPTH],
         input logic [`REJECT_DEPTH-1:0] vld);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `REJECT_DEPTH; i++) begin
         if (vld[i] && ids[i] == id) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : is_rejected

   // presence of the learned actuator, never a replaced one
   assign tif.learned_match = learned_valid && tif.tag_valid &&
      tif.tag_id == learned_id &&
      !is_rejected(tif.tag_id, reject_id, reject_valid);
   assign tif.teach_slow = (st == T_DETECT);
   assign tif.teach_fast = (st == T_WINDOW);
   assign tif.remaining = remaining;

   // next-state of store and teach sequence
   always_comb begin
      next_learned_valid = learned_valid;
      next_learned_id = learned_id;
      next_remaining = remaining;
      next_reject_id = reject_id;
      next_reject_valid = reject_valid;
      next_cand_id = cand_id;
      next_st = st;
      next_timer = timer;
      slot = `REJECT_IDX_W'(`LEARN_MAX - remaining);
      cand_lost = !tif.tag_valid || !tif.tag_sole || tif.tag_id != cand_id;
      if (!learned_valid && tif.ready && tif.tag_valid &&
            !is_rejected(tif.tag_id, reject_id, reject_valid)) begin
         next_learned_valid = 1'b1;
         next_learned_id = tif.tag_id;
      end
      unique case (st)
         T_IDLE: begin
            if (tif.ready && learned_valid && tif.tag_valid &&
                  tif.tag_sole && tif.tag_id != learned_id &&
                  !is_rejected(tif.tag_id, reject_id, reject_valid) &&
                  remaining != '0) begin
               next_st = T_DETECT;
               next_cand_id = tif.tag_id;
               next_timer = '0;
            end
         end
         T_DETECT: begin
            if (!tif.supply_ok || cand_lost) begin
               next_st = T_IDLE;
            end else if (tif.tick_ms) begin
               if (timer == `TIMER_W'(DETECT_MS - 1)) begin
                  next_st = T_WINDOW;
                  next_timer = '0;
               end else begin
                  next_timer = timer + 1'b1;
               end
            end
         end
         T_WINDOW: begin
            if (!tif.supply_ok) begin
               next_st = T_ARMED;
            end else if (cand_lost) begin
               next_st = T_IDLE;
            end else if (tif.tick_ms) begin
               if (timer == `TIMER_W'(CONFIRM_MS - 1)) begin
                  next_st = T_IDLE;
               end else begin
                  next_timer = timer + 1'b1;
               end
            end
         end
         T_ARMED: begin
            if (tif.supply_ok) begin
               next_reject_valid[slot] = 1'b1;
               next_reject_id[slot] = learned_id;
               next_learned_id = cand_id;
               next_remaining = remaining - 1'b1;
               next_st = T_IDLE;
            end
         end
      endcase
   end

   // registers; only the global reset clears the store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         learned_valid <= 1'b0;
         learned_id <= '0;
         remaining <= `LEARN_MAX;
         reject_id <= '{default: '0};
         reject_valid <= '0;
         cand_id <= '0;
         st <= T_IDLE;
         timer <= '0;
      end else begin
         learned_valid <= next_learned_valid;
         learned_id <= next_learned_id;
         remaining <= next_remaining;
         reject_id <= next_reject_id;
         reject_valid <= next_reject_valid;
         cand_id <= next_cand_id;
         st <= next_st;
         timer <= next_timer;
      end
   end

   AST_EXHAUSTED: assert property (
      (st == T_IDLE && remaining == '0) |=> (st == T_IDLE))
      else $error("teach started with counter exhausted");
   AST_ABANDON: assert property (
      ((st == T_DETECT || st == T_WINDOW) && tif.supply_ok &&
       !tif.tag_valid) |=> (st == T_IDLE && remaining == $past(remaining)))
      else $error("teach not abandoned on actuator loss");
   AST_COMMIT: assert property (
      (st == T_ARMED && tif.supply_ok) |=>
      (remaining == $past(remaining) - 1'b1 && learned_id == $past(cand_id)))
      else $error("confirmed teach not committed");
   AST_NO_RELEARN: assert property (
      is_rejected(tif.tag_id, reject_id, reject_valid) |->
      (!tif.learned_match && tif.tag_id != learned_id))
      else $error("replaced actuator accepted");
   AST_WINDOW_EXPIRY: assert property (
      (st == T_WINDOW && tif.supply_ok && !cand_lost && tif.tick_ms &&
       timer == `TIMER_W'(CONFIRM_MS - 1)) |=> (st == T_IDLE))
      else $error("confirmation window did not expire");

endmodule : teach_unit
`default_nettype wire

// File: verif/eval_device.sv
`default_nettype none
module eval_device (
   input wire logic clk,
   input wire logic open_both,
   input wire logic want_ch1,
   input wire logic want_ch2,
   input wire logic out_ch1,
   input wire logic out_ch2,
   output logic in_ch1,
   output logic in_ch2,
   output logic gate_ok
);
   timeunit 1ns;
   timeprecision 100ps;

   // channels start open so the switch sees a defined level
   initial begin
      in_ch1 = 1'b0;
      in_ch2 = 1'b0;
   end

   // drive both input channels, opening both together on request
   always @(posedge clk) begin
      in_ch1 <= want_ch1 & ~open_both;
      in_ch2 <= want_ch2 & ~open_both;
   end

   // two-channel evaluation: enabled only with both outputs high
   assign gate_ok = out_ch1 & out_ch2;
endmodule : eval_device
`default_nettype wire

// File: verif/safety_interlock_output_teach_logic_tb.sv
`include "interlock_params.svh"
`default_nettype none
module safety_interlock_output_teach_logic_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rstn, supply, tag_valid, tag_sole, want1, want2, open_both;
   logic [`ID_W-1:0] tag_id;
   logic in1, in2, out1, out2, pres, green, gate, led_in, gate_ok;
   logic [`CNT_W-1:0] remaining;
   int n_fail = 0;
   int samples_checked = 0;

   // shortened ms tick and teach times keep the run brief
   safety_interlock #(.MS_CYCLES(2), .READY_MS(2), .DETECT_MS(1200),
      .CONFIRM_MS(1200)) DUT (
      .REF_CLK(clk), .RSTN(rstn), .SUPPLY_OK(supply),
      .TAG_VALID(tag_valid), .TAG_SOLE(tag_sole), .TAG_ID(tag_id),
      .SAFETY_IN_CH1(in1), .SAFETY_IN_CH2(in2),
      .SAFETY_OUT_CH1(out1), .SAFETY_OUT_CH2(out2),
      .PRESENCE_SIGNAL_OUT(pres), .LED_POWER_GREEN(green),
      .LED_GATE(gate), .LED_INPUT(led_in), .LEARN_REMAINING(remaining)
   );

   eval_device u_eval (
      .clk(clk), .open_both(open_both), .want_ch1(want1),
      .want_ch2(want2), .out_ch1(out1), .out_ch2(out2),
      .in_ch1(in1), .in_ch2(in2), .gate_ok(gate_ok)
   );

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic settle;
      @(negedge clk);
   endtask : settle

   task automatic drive_tag(input logic v, input logic s,
                            input logic [7:0] id);
      @(posedge clk);
      tag_valid <= v;
      tag_sole <= s;
      tag_id <= id;
   endtask : drive_tag

   task automatic set_in(input logic a, input logic b);
      @(posedge clk);
      want1 <= a;
      want2 <= b;
   endtask : set_in

   task automatic power_cycle;
      @(posedge clk);
      supply <= 1'b0;
      cyc(10);
      supply <= 1'b1;
   endtask : power_cycle

   // bounded wait for the ready indicator
   task automatic wait_green;
      int k;
      k = 0;
      while (green !== 1'b1 && k < 400) begin
         settle();
         k++;
      end
      chk(8'(green), 8'h01);
      cyc(4);
      settle();
   endtask : wait_green

   // count level changes of the gate (sel=1) or input indicator
   task automatic toggles(input bit sel, input int n, output int t);
      logic last;
      t = 0;
      settle();
      last = sel ? gate : led_in;
      repeat (n) begin
         settle();
         if ((sel ? gate : led_in) !== last) t++;
         last = sel ? gate : led_in;
      end
   endtask : toggles

   // full teach-in with confirmation by a power interruption
   task automatic teach(input logic [7:0] id, input bit look);
      int t;
      drive_tag(1'b1, 1'b1, id);
      if (look) begin
         cyc(20);
         toggles(1'b1, 2000, t);
         chk(8'(t >= 1 && t <= 3), 8'h01);
         cyc(1000);
         toggles(1'b1, 1000, t);
         chk(8'(t >= 3), 8'h01);
      end else begin
         cyc(3600);
      end
      power_cycle();
      wait_green();
   endtask : teach

   // output table while ready, with inputs separated by both-low steps
   task automatic t_table;
      logic [1:0] pat [3] = '{2'b01, 2'b10, 2'b11};
      for (int i = 0; i < 3; i++) begin
         set_in(1'b0, 1'b0);
         cyc(4);
         settle();
         chk({out1, out2, pres}, 8'h01);
         set_in(pat[i][1], pat[i][0]);
         cyc(4);
         settle();
         chk({out1, out2}, {6'h0, pat[i]});
         chk(8'(pres), 8'h01);
      end
      drive_tag(1'b0, 1'b0, 8'hA1);
      cyc(4);
      settle();
      chk({out1, out2, pres}, 8'h00);
      drive_tag(1'b1, 1'b0, 8'hA1);
      cyc(4);
   endtask : t_table

   // unequal inputs, lock, and release by opening both channels
   task automatic t_plaus;
      int t;
      set_in(1'b0, 1'b1);
      cyc(4);
      settle();
      chk({out1, out2}, 8'h01);
      toggles(1'b0, 1200, t);
      chk(8'(t != 0), 8'h01);
      set_in(1'b1, 1'b1);
      cyc(4);
      settle();
      chk({out1, out2, gate_ok}, 8'h00);
      toggles(1'b0, 1200, t);
      chk(8'(t != 0), 8'h01);
      chk({out1, out2}, 8'h00);
      @(posedge clk);
      open_both <= 1'b1;
      cyc(3);
      open_both <= 1'b0;
      cyc(5);
      settle();
      chk({out1, out2, led_in}, 8'h07);
   endtask : t_plaus

   // start a teach-in, take the actuator away; then let a window expire
   task automatic t_abandon;
      drive_tag(1'b1, 1'b1, 8'hC3);
      cyc(500);
      drive_tag(1'b0, 1'b0, 8'hC3);
      cyc(10);
      power_cycle();
      wait_green();
      chk(8'(remaining), 8'h07);
      drive_tag(1'b1, 1'b0, 8'hB2);
      cyc(4);
      settle();
      chk({out1, out2, pres}, 8'h07);
      drive_tag(1'b1, 1'b1, 8'hD4);
      cyc(5200);
      power_cycle();
      drive_tag(1'b1, 1'b0, 8'hB2);
      wait_green();
      chk(8'(remaining), 8'h07);
      chk({out1, out2, pres}, 8'h07);
   endtask : t_abandon

   // watchdog
   initial begin
      #1200000;
      n_fail++;
      conclude();
   end

   // main sequence
   initial begin
      rstn = 1'b0;
      supply = 1'b1;
      tag_valid = 1'b1;
      tag_sole = 1'b0;
      tag_id = 8'hA1;
      want1 = 1'b1;
      want2 = 1'b1;
      open_both = 1'b0;
      cyc(8);
      settle();
      chk({out1, out2, pres, green}, 8'h00);
      chk(8'(remaining), 8'h08);
      cyc(8);
      rstn <= 1'b1;
      settle();
      chk({out1, out2, pres, green}, 8'h00);
      wait_green();
      chk({out1, out2, pres}, 8'h07);
      chk(8'(remaining), 8'h08);
      t_table();
      t_plaus();
      teach(8'hB2, 1'b1);
      chk(8'(remaining), 8'h07);
      chk(8'(pres), 8'h01);
      drive_tag(1'b1, 1'b1, 8'hA1);
      cyc(4);
      settle();
      chk({out1, out2, pres}, 8'h00);
      t_abandon();
      for (int i = 0; i < 7; i++) begin
         teach(8'h10 + 8'(i), 1'b0);
      end
      chk(8'(remaining), 8'h00);
      teach(8'h20, 1'b0);
      chk(8'(remaining), 8'h00);
      chk(8'(pres), 8'h00);
      conclude();
   end
endmodule : safety_interlock_output_teach_logic_tb
`default_nettype wire
